// ### nvs_pkg.sv
// Package for the shadowed static memory host controller.
// Assumes a 20 MHz clock and an asynchronous memory on the far side.
package nvs_pkg;

    // Widths of the memory port.
    localparam int ADDR_W = 15;
    localparam int DATA_W = 8;
    localparam int KEY_W  = 14;
    localparam int KEY_N  = 6;

    // Key addresses, taken on the lower 14 address bits.
    localparam logic [13:0] KEY_0      = 14'h0e38;
    localparam logic [13:0] KEY_1      = 14'h31c7;
    localparam logic [13:0] KEY_2      = 14'h03e0;
    localparam logic [13:0] KEY_3      = 14'h3c1f;
    localparam logic [13:0] KEY_4      = 14'h303f;
    localparam logic [13:0] KEY_STORE  = 14'h0fc0;
    localparam logic [13:0] KEY_RECALL = 14'h0c63;

    // Clock rate and bus phase timing.
    localparam int CLK_MHZ      = 20;
    localparam int PHASE_NS     = 100;
    localparam int PHASE_CYC    = (PHASE_NS * CLK_MHZ + 999) / 1000;
    localparam int CNT_W        = 24;

    // Busy times in microseconds; defaults only, the device gives none.
    localparam int STORE_US     = 10000;
    localparam int RECALL_US    = 20;
    localparam int PWRUP_US     = 20000;
    localparam int STORE_CYC    = STORE_US * CLK_MHZ;
    localparam int RECALL_CYC   = RECALL_US * CLK_MHZ;
    localparam int PWRUP_CYC    = PWRUP_US * CLK_MHZ;

    // Host commands.
    typedef enum logic [1:0] {
        NVS_CMD_READ,
        NVS_CMD_WRITE,
        NVS_CMD_STORE,
        NVS_CMD_RECALL
    } nvs_cmd_t;

    // Memory-side pin group.
    typedef struct packed {
        logic                chip_select_n;
        logic                write_strobe_n;
        logic                output_drive_n;
        logic [ADDR_W-1:0]   byte_address;
        logic [DATA_W-1:0]   data_out;
        logic                data_oe;
    } nvs_pins_t;

    // Returns the key address for one step of a sequence.
    function automatic logic [13:0] nvs_key(input logic [2:0] step, input logic recall);
        logic [13:0] k;
        k = KEY_0;
        case (step)
            3'h0: k = KEY_0;
            3'h1: k = KEY_1;
            3'h2: k = KEY_2;
            3'h3: k = KEY_3;
            3'h4: k = KEY_4;
            default: k = recall ? KEY_RECALL : KEY_STORE;
        endcase
        return k;
    endfunction

endpackage

// ### nvs_wait.sv
// Busy-wait timer: counts a loaded number of cycles down to zero.
// Assumes load and count come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module nvs_wait
    import nvs_pkg::*;
#(
    parameter int W = CNT_W
) (
    input  wire logic         mclk_i,
    input  wire logic         rst_b_i,
    input  wire logic         load_i,
    input  wire logic [W-1:0] count_i,
    output logic              done_o
);

    // Remaining cycles.
    logic [W-1:0] cnt_ff;
    logic [W-1:0] nxt_cnt;

    // Next count: load wins, otherwise count down to zero.
    always_comb begin
        nxt_cnt = cnt_ff;
        if (load_i) begin
            nxt_cnt = count_i;
        end else if (cnt_ff != '0) begin
            nxt_cnt = cnt_ff - 1'b1;
        end
    end

    // Counter register.
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    // Done while idle and not being loaded.
    assign done_o = (cnt_ff == '0) && !load_i;

endmodule
`default_nettype wire

// ### nvs_host.sv
// Host controller driving a shadowed static memory over its pins.
// Assumes the memory is asynchronous; read data and the supply-good
// level come from outside and are synchronised here.
`timescale 1ns/1ps
`default_nettype none
module nvs_host
    import nvs_pkg::*;
#(
    parameter int STORE_CYCLES  = STORE_CYC,
    parameter int RECALL_CYCLES = RECALL_CYC,
    parameter int PWRUP_CYCLES  = PWRUP_CYC
) (
    input  wire logic              mclk_i,
    input  wire logic              rst_b_i,
    input  wire logic              req_valid_i,
    input  wire nvs_cmd_t          req_cmd_i,
    input  wire logic [ADDR_W-1:0] req_addr_i,
    input  wire logic [DATA_W-1:0] req_wdata_i,
    input  wire logic              supply_ok_i,
    input  wire logic [DATA_W-1:0] data_bus_i,
    output logic                   req_ready_o,
    output logic                   rsp_valid_o,
    output logic [DATA_W-1:0]      rsp_rdata_o,
    output logic                   busy_o,
    output nvs_pins_t              pins_o
);

    ////////////////////////////////////////////////////////////////////////
    // State.

    // Controller phases.
    typedef enum logic [2:0] {
        ST_PWRUP,
        ST_IDLE,
        ST_SETUP,
        ST_STROBE,
        ST_HOLD,
        ST_WAIT
    } nvs_state_t;

    // Registered state of the controller, apart from the input synchronisers and the busy timer.
    typedef struct packed {
        nvs_state_t        state;
        nvs_cmd_t          cmd;
        logic [2:0]        step;
        logic [7:0]        phase;
        logic              ready;
        logic              rsp_valid;
        logic [DATA_W-1:0] rdata;
        logic              busy;
        logic              wait_load;
        logic [CNT_W-1:0]  wait_cnt;
        nvs_pins_t         pins;
    } nvs_host_t;

    localparam logic [7:0] PHASE_LAST = 8'(PHASE_CYC - 1);

    nvs_host_t s_ff;         // Registered state.
    nvs_host_t nxt_s;        // Next state.
    logic [DATA_W-1:0] dq_m_ff;   // First synchroniser stage of read data.
    logic [DATA_W-1:0] dq_s_ff;   // Second synchroniser stage of read data.
    logic              ok_m_ff;   // First stage of supply-good.
    logic              ok_s_ff;   // Second stage of supply-good.
    logic              wait_done; // Busy timer has run out.

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers.

    // Two flip-flops on every level that comes from off chip.
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            dq_m_ff <= 8'h00;
            dq_s_ff <= 8'h00;
            ok_m_ff <= 1'b0;
            ok_s_ff <= 1'b0;
        end else begin
            dq_m_ff <= data_bus_i;
            dq_s_ff <= dq_m_ff;
            ok_m_ff <= supply_ok_i;
            ok_s_ff <= ok_m_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Busy timer.

    nvs_wait #(
        .W       (CNT_W)
    ) u_wait (
        .mclk_i  (mclk_i),
        .rst_b_i (rst_b_i),
        .load_i  (s_ff.wait_load),
        .count_i (s_ff.wait_cnt),
        .done_o  (wait_done)
    );

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic.

    // Sequences reads, writes and six-read key sequences on the pins.
    always_comb begin
        nxt_s           = s_ff;
        nxt_s.rsp_valid = 1'b0;
        nxt_s.wait_load = 1'b0;
        unique case (s_ff.state)
            // Power-up recall: wait for supply, then the power-up time.
            ST_PWRUP: begin
                nxt_s.busy  = 1'b1;
                nxt_s.ready = 1'b0;
                if (!ok_s_ff) begin
                    // Supply lost again: the whole recall wait restarts once it is back.
                    nxt_s.step = 3'h0;
                end else if (!s_ff.wait_load && wait_done) begin
                    if (s_ff.step == 3'h0) begin
                        nxt_s.wait_load = 1'b1;
                        nxt_s.wait_cnt  = CNT_W'(PWRUP_CYCLES);
                        nxt_s.step      = 3'h1;
                    end else begin
                        nxt_s.state = ST_IDLE;
                        nxt_s.step  = 3'h0;
                        nxt_s.busy  = 1'b0;
                        nxt_s.ready = 1'b1;
                    end
                end
            end
            // Idle: take a request; strobes held high so no write is pending.
            ST_IDLE: begin
                nxt_s.pins.chip_select_n  = 1'b1;
                nxt_s.pins.write_strobe_n = 1'b1;
                nxt_s.pins.output_drive_n = 1'b1;
                nxt_s.pins.data_oe        = 1'b0;
                if (!ok_s_ff) begin
                    nxt_s.state = ST_PWRUP;
                    nxt_s.step  = 3'h0;                                  // Power-up step starts again from zero, so the wait reloads.
                    nxt_s.ready = 1'b0;
                    nxt_s.busy  = 1'b1;
                end else if (req_valid_i && s_ff.ready) begin
                    nxt_s.cmd   = req_cmd_i;
                    nxt_s.ready = 1'b0;
                    nxt_s.step  = 3'h0;
                    nxt_s.phase = 8'h00;
                    nxt_s.state = ST_SETUP;
                    // Address is set up before select falls.
                    if (req_cmd_i == NVS_CMD_STORE || req_cmd_i == NVS_CMD_RECALL) begin
                        nxt_s.pins.byte_address = {1'b0, nvs_key(3'h0, 1'b0)};
                    end else begin
                        nxt_s.pins.byte_address = req_addr_i;
                    end
                    nxt_s.pins.data_out = req_wdata_i;
                    nxt_s.pins.data_oe  = (req_cmd_i == NVS_CMD_WRITE);
                end
            end
            // Setup phase: address settles, then select falls, with the write strobe for a write or output drive for a read.
            ST_SETUP: begin
                nxt_s.phase = s_ff.phase + 8'h01;
                if (s_ff.phase == PHASE_LAST) begin
                    nxt_s.phase              = 8'h00;
                    nxt_s.state              = ST_STROBE;
                    nxt_s.pins.chip_select_n = 1'b0;
                    if (s_ff.cmd == NVS_CMD_WRITE) begin
                        nxt_s.pins.write_strobe_n = 1'b0;
                        nxt_s.pins.output_drive_n = 1'b1;
                    end else if (s_ff.cmd == NVS_CMD_READ) begin
                        nxt_s.pins.output_drive_n = 1'b0;
                    end else begin
                        nxt_s.pins.output_drive_n = 1'b1;
                    end
                end
            end
            // Strobe phase: hold the access long enough for the memory.
            ST_STROBE: begin
                nxt_s.phase = s_ff.phase + 8'h01;
                if (s_ff.phase == PHASE_LAST + 8'h02) begin
                    // Read data has had two extra cycles to pass the synchroniser.
                    nxt_s.rdata               = dq_s_ff;
                    nxt_s.phase               = 8'h00;
                    nxt_s.state               = ST_HOLD;
                    nxt_s.pins.chip_select_n  = 1'b1;
                    nxt_s.pins.write_strobe_n = 1'b1;
                    nxt_s.pins.output_drive_n = 1'b1;
                end
            end
            // Hold phase: address and data stay put after the ending edge.
            ST_HOLD: begin
                nxt_s.phase = s_ff.phase + 8'h01;
                if (s_ff.phase == PHASE_LAST) begin
                    nxt_s.phase        = 8'h00;
                    nxt_s.pins.data_oe = 1'b0;
                    if ((s_ff.cmd == NVS_CMD_STORE || s_ff.cmd == NVS_CMD_RECALL) && s_ff.step != 3'h5) begin
                        // Next key read follows at once; nothing else may intervene.
                        nxt_s.step              = s_ff.step + 3'h1;
                        nxt_s.pins.byte_address = {1'b0, nvs_key(s_ff.step + 3'h1,
                                                   s_ff.cmd == NVS_CMD_RECALL)};
                        nxt_s.state             = ST_SETUP;
                    end else if (s_ff.cmd == NVS_CMD_STORE) begin
                        nxt_s.state     = ST_WAIT;
                        nxt_s.busy      = 1'b1;
                        nxt_s.wait_load = 1'b1;
                        nxt_s.wait_cnt  = CNT_W'(STORE_CYCLES);
                    end else if (s_ff.cmd == NVS_CMD_RECALL) begin
                        nxt_s.state     = ST_WAIT;
                        nxt_s.busy      = 1'b1;
                        nxt_s.wait_load = 1'b1;
                        nxt_s.wait_cnt  = CNT_W'(RECALL_CYCLES);
                    end else begin
                        nxt_s.state     = ST_IDLE;
                        nxt_s.ready     = 1'b1;
                        nxt_s.rsp_valid = 1'b1;
                    end
                end
            end
            // Wait out a store or recall; the memory is inaccessible meanwhile.
            ST_WAIT: begin
                if (!s_ff.wait_load && wait_done) begin
                    nxt_s.state     = ST_IDLE;
                    nxt_s.busy      = 1'b0;
                    nxt_s.ready     = 1'b1;
                    nxt_s.rsp_valid = 1'b1;
                end
            end
            default: begin
                nxt_s.state = ST_IDLE;
            end
        endcase
        // Low supply: the device ignores writes and stores anyway.
        if (!ok_s_ff && s_ff.state == ST_IDLE) begin
            nxt_s.ready = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register.

    // Resets to power-up wait with all strobes high.
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s_ff <= '{state: ST_PWRUP, cmd: NVS_CMD_READ, step: 3'h0, phase: 8'h00,
                      ready: 1'b0, rsp_valid: 1'b0, rdata: 8'h00, busy: 1'b1,
                      wait_load: 1'b0, wait_cnt: 24'h000000,
                      pins: '{chip_select_n: 1'b1, write_strobe_n: 1'b1, output_drive_n: 1'b1,
                              byte_address: 15'h0000, data_out: 8'h00, data_oe: 1'b0}};
        end else begin
            s_ff <= nxt_s;
        end
    end

    // Outputs straight from the state register.
    assign req_ready_o = s_ff.ready;
    assign rsp_valid_o = s_ff.rsp_valid;
    assign rsp_rdata_o = s_ff.rdata;
    assign busy_o      = s_ff.busy;
    assign pins_o      = s_ff.pins;

endmodule
`default_nettype wire

// ### nvs_host_asserts.sv
// Checker for the host controller of the shadowed static memory.
// Assumes it is bound to the host module and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module nvs_host_chk
    import nvs_pkg::*;
#(
    parameter int STORE_CYCLES  = STORE_CYC,
    parameter int RECALL_CYCLES = RECALL_CYC,
    parameter int PWRUP_CYCLES  = PWRUP_CYC
) (
    input wire logic     mclk_i,
    input wire logic     rst_b_i,
    input wire logic     req_valid_i,
    input wire nvs_cmd_t req_cmd_i,
    input wire logic     supply_ok_i,
    input wire logic     req_ready_o,
    input wire logic     rsp_valid_o,
    input wire logic     busy_o,
    input wire nvs_pins_t pins_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);

    ////////////////////////////////////////////////////////////////////////////////
    // A taken read or write selects the memory soon and then answers.
    sequence s_rw_take;
        req_valid_i && req_ready_o && (req_cmd_i == NVS_CMD_READ || req_cmd_i == NVS_CMD_WRITE);
    endsequence
    sequence s_rw_select;
        ##[1:6] !pins_o.chip_select_n;
    endsequence
    sequence s_rw_done;
        ##[1:12] rsp_valid_o;
    endsequence

    a_rw_answer_time: assert property (s_rw_take |-> s_rw_select ##0 s_rw_done)
        else $error("read or write not answered in time");
    a_read_oe_only: assert property (!pins_o.output_drive_n |->
                                     !pins_o.chip_select_n && pins_o.write_strobe_n)
        else $error("output drive low outside a read");
    a_write_no_drive: assert property (!pins_o.write_strobe_n |-> pins_o.output_drive_n)
        else $error("output drive low during a write");
    a_write_data_on: assert property (!pins_o.chip_select_n && !pins_o.write_strobe_n |-> pins_o.data_oe)
        else $error("write without data driven");
    a_write_data_held: assert property ($rose(pins_o.write_strobe_n) |-> pins_o.data_oe)
        else $error("data released before write end");
    a_wr_addr_stable: assert property ((!pins_o.chip_select_n && !pins_o.write_strobe_n) [*2]
                                       |-> $stable(pins_o.byte_address))
        else $error("address moved in a write");
    a_strobe_in_select: assert property ($fell(pins_o.write_strobe_n)
                                         |-> (!pins_o.write_strobe_n && !pins_o.chip_select_n) [*3])
        else $error("write strobe too short or unselected");
    a_busy_no_access: assert property (busy_o |-> !req_ready_o && pins_o.chip_select_n)
        else $error("access while busy");
    a_rsp_one_cycle: assert property (rsp_valid_o |=> !rsp_valid_o)
        else $error("response longer than one cycle");
    a_low_supply_refuse: assert property (!supply_ok_i [*4] |-> !req_ready_o)
        else $error("ready while supply low");
endmodule
`default_nettype wire

// ### nvs_mem_model.sv
// Behavioural model of the shadowed static memory beyond the host.
// Assumes the bench resolves the shared data bus and feeds it back.
`timescale 1ns/1ps
`default_nettype none
module nvs_mem_model
    import nvs_pkg::*;
#(
    parameter int STORE_NS  = 750,
    parameter int RECALL_NS = 400,
    parameter int PWRUP_NS  = 1250
) (
    input  wire nvs_pins_t         pins_i,
    input  wire logic              supply_ok_i,
    input  wire logic [DATA_W-1:0] data_bus_i,
    output logic [DATA_W-1:0]      dev_q_o,
    output logic                   dev_oe_o
);
    logic [DATA_W-1:0] sram  [2**ADDR_W];  // Volatile array.
    logic [DATA_W-1:0] nvram [2**ADDR_W];  // Shadow array.
    logic [13:0]       keys  [KEY_N-1];    // First five key addresses.
    logic              busy;               // High while a copy runs.
    logic              wr_seen;            // A write happened in this select.
    logic [2:0]        step;               // Keys matched so far.
    logic              wr;                 // Write state on the pins.
    logic [13:0]       low_a;              // Key decode address.

    // Shadow starts with a known pattern; a power-up recall is pending.
    initial begin
        keys = '{KEY_0, KEY_1, KEY_2, KEY_3, KEY_4};
        for (int i = 0; i < 2**ADDR_W; i++) begin
            nvram[i] = 8'(i) ^ 8'h5a;
            sram[i] = 8'h00;
        end
        busy = 1'b1;
        wr_seen = 1'b0;
        step = 3'h0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Reads drive while selected, enabled and not writing, never when busy.
    assign wr       = !pins_i.chip_select_n && !pins_i.write_strobe_n;
    assign dev_oe_o = !busy && !pins_i.chip_select_n && !pins_i.output_drive_n && pins_i.write_strobe_n;
    assign dev_q_o  = sram[pins_i.byte_address];
    assign low_a    = pins_i.byte_address[13:0];

    // A write is noted as it begins, so the select edge that ends it always sees it.
    always @(posedge wr) wr_seen = 1'b1;

    // A write takes the bus at its terminating edge, unless busy or supply is low.
    always @(negedge wr) begin
        if (!busy && supply_ok_i) begin
            sram[pins_i.byte_address] = data_bus_i;
        end
    end

    // Each select-delimited read of the next key advances the key match; a read of the first key restarts it at one; anything else drops it.
    always @(posedge pins_i.chip_select_n) begin
        if (wr_seen || busy) begin
            step = 3'h0;
        end else if (step == 3'h5 && low_a == KEY_STORE && supply_ok_i) begin
            step = 3'h0;
            busy = 1'b1;
            nvram = '{default: 8'hff};
            #STORE_NS;
            nvram = sram;
            busy = 1'b0;
        end else if (step == 3'h5 && low_a == KEY_RECALL) begin
            step = 3'h0;
            busy = 1'b1;
            sram = '{default: 8'h00};
            #RECALL_NS;
            sram = nvram;
            busy = 1'b0;
        end else if (step < 3'h5 && low_a == keys[step]) begin
            step = step + 3'h1;
        end else begin
            step = (low_a == KEY_0) ? 3'h1 : 3'h0;
        end
        wr_seen = 1'b0;
    end

    // Supply loss latches a recall that runs once supply is back.
    always @(negedge supply_ok_i) busy = 1'b1;
    always @(posedge supply_ok_i) begin
        #PWRUP_NS;
        sram = nvram;
        busy = 1'b0;
    end
endmodule
`default_nettype wire

// ### tb_shadowed_sram_store_recall.sv
// Self-checking bench for the host controller with a memory model.
// Assumes short busy counts so that the run stays brief.
`timescale 1ns/1ps
`default_nettype none
module tb_shadowed_sram_store_recall import nvs_pkg::*;;
    logic        mclk_i, rst_b_i, req_valid_i, supply_ok_i, req_ready_o, rsp_valid_o, busy_o, dev_oe;
    nvs_cmd_t    req_cmd_i;
    logic [14:0] req_addr_i;
    logic [7:0]  req_wdata_i, rsp_rdata_o, dev_q, last_bus;
    wire  [7:0]  bus;
    nvs_pins_t   pins_o;
    logic [8:0]  expq [$];     // Notes: read flag and byte.
    logic [7:0]  sh [int];     // Expected volatile overrides.
    logic [7:0]  nvsh [int];   // Expected shadow overrides.
    int          error_cnt, checked;

    nvs_host #(.STORE_CYCLES(20), .RECALL_CYCLES(10), .PWRUP_CYCLES(30)) u_dut (
        .mclk_i(mclk_i), .rst_b_i(rst_b_i), .req_valid_i(req_valid_i), .req_cmd_i(req_cmd_i),
        .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i), .supply_ok_i(supply_ok_i),
        .data_bus_i(bus), .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o),
        .rsp_rdata_o(rsp_rdata_o), .busy_o(busy_o), .pins_o(pins_o));
    nvs_mem_model u_mem (.pins_i(pins_o), .supply_ok_i(supply_ok_i), .data_bus_i(bus),
                         .dev_q_o(dev_q), .dev_oe_o(dev_oe));

    // Undriven bus shows a changing pattern, never a held value.
    assign bus = pins_o.data_oe ? pins_o.data_out : (dev_oe ? dev_q : ~last_bus);
    always @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            last_bus <= 8'h00;
        end else begin
            last_bus <= bus;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Comparisons for bytes and flags.
    task automatic check8(input string n, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic check1(input string n, input logic e, input logic g);
        checked++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %s expected %b seen %b", n, e, g);
        end
    endtask
    function automatic logic [7:0] exp_of(input logic [14:0] a);
        return sh.exists(int'(a)) ? sh[int'(a)] : (a[7:0] ^ 8'h5a);
    endfunction

    // One request: wait ready, present for one edge, wait for the answer.
    task automatic op(input nvs_cmd_t c, input logic [14:0] a, input logic [7:0] d);
        int   n;
        logic saw;
        n = 0;
        saw = 1'b0;
        while (req_ready_o !== 1'b1 && n < 2000) begin
            @(posedge mclk_i);
            #2;
            n++;
        end
        expq.push_back({c == NVS_CMD_READ, exp_of(a)});
        if (c == NVS_CMD_WRITE) sh[int'(a)] = d;
        if (c == NVS_CMD_STORE) nvsh = sh;
        if (c == NVS_CMD_RECALL) sh = nvsh;
        req_valid_i = 1'b1;
        req_cmd_i = c;
        req_addr_i = a;
        req_wdata_i = d;
        @(posedge mclk_i);
        #2;
        req_valid_i = 1'b0;
        n = 0;
        while (rsp_valid_o !== 1'b1 && n < 2000) begin
            saw |= (busy_o === 1'b1);
            @(posedge mclk_i);
            #2;
            n++;
        end
        check1("answered", 1'b1, rsp_valid_o);
        if (c == NVS_CMD_STORE || c == NVS_CMD_RECALL) check1("busy", 1'b1, saw);
    endtask

    // Takes the oldest note whenever an answer appears; looks mid-cycle, where outputs are settled.
    always @(negedge mclk_i) begin
        if (rsp_valid_o === 1'b1) begin
            if (expq.size() == 0) begin
                error_cnt++;
                $display("Error answer expected none seen one");
            end else if (expq[0][8]) begin
                check8("rdata", expq[0][7:0], rsp_rdata_o);
                void'(expq.pop_front());
            end else begin
                void'(expq.pop_front());
            end
        end
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Clock, watchdog and the test sequence.
    initial begin
        mclk_i = 1'b0;
        forever #25 mclk_i = ~mclk_i;
    end
    initial begin
        #1000000;
        error_cnt++;
        $display("Error watchdog expected end seen hang");
        report_and_stop();
    end
    initial begin
        logic [14:0] aa [8];
        logic [7:0]  d;
        error_cnt = 0;
        checked = 0;
        rst_b_i = 1'b0;
        req_valid_i = 1'b0;
        req_cmd_i = NVS_CMD_READ;
        req_addr_i = 15'h0000;
        req_wdata_i = 8'h00;
        supply_ok_i = 1'b0;
        void'($urandom(32'h71e0777b));
        repeat (10) @(posedge mclk_i);
        #2;
        rst_b_i = 1'b1;
        supply_ok_i = 1'b1;
        for (int i = 0; i < 4; i++) op(NVS_CMD_READ, 15'($urandom), 8'h00);
        $display("test power_up done");
        for (int i = 0; i < 8; i++) aa[i] = (i == 0) ? 15'h0000 : (i == 7) ? 15'h7fff : 15'($urandom);
        for (int i = 0; i < 8; i++) op(NVS_CMD_WRITE, aa[i], 8'($urandom));
        for (int i = 0; i < 8; i++) op(NVS_CMD_READ, aa[i], 8'h00);
        $display("test write_read done");
        d = 8'($urandom);
        op(NVS_CMD_WRITE, aa[1], d);
        op(NVS_CMD_STORE, 15'h0000, 8'h00);
        op(NVS_CMD_WRITE, aa[1], ~d);
        op(NVS_CMD_READ, aa[1], 8'h00);
        op(NVS_CMD_RECALL, 15'h0000, 8'h00);
        op(NVS_CMD_READ, aa[1], 8'h00);
        op(NVS_CMD_RECALL, 15'h0000, 8'h00);
        op(NVS_CMD_READ, aa[1], 8'h00);
        $display("test store_recall done");
        op(NVS_CMD_WRITE, aa[1], 8'h3c);
        supply_ok_i = 1'b0;
        repeat (6) @(posedge mclk_i);
        #2;
        check1("ready_low", 1'b0, req_ready_o);
        supply_ok_i = 1'b1;
        sh = nvsh;
        op(NVS_CMD_READ, aa[1], 8'h00);
        op(NVS_CMD_READ, aa[2], 8'h00);
        $display("test supply_drop done");
        report_and_stop();
    end
endmodule

bind nvs_host nvs_host_chk #(
    .STORE_CYCLES(STORE_CYCLES), .RECALL_CYCLES(RECALL_CYCLES), .PWRUP_CYCLES(PWRUP_CYCLES)
) u_chk (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .req_valid_i(req_valid_i), .req_cmd_i(req_cmd_i),
    .supply_ok_i(supply_ok_i), .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o),
    .busy_o(busy_o), .pins_o(pins_o));
`default_nettype wire
